// [core/id_controller_cancel_and_raw_cmd.v]
// Overview of operation
// - Cancel frame stops ordinary command processing, not polling; controller awaits commands.
// - Cancel result is two words; second holds completion code 00 or 14.
// - Completion code 75 before receive/sync/tag detect, 76 during tag read/write.
// - Polling read cancel uses four send words: count, unit, unused, head digit.
// - Polling cancel result: word count, then completion code 75 or 76.
// - Polling write cancel shares layouts and codes with polling read cancel.
// - General command frames payload with start, check and terminator; reply stripped.
// - Reply stored as BCD count 1 to 127, then ASCII payload words.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "idcmd_map.vh"
module id_controller_cancel_and_raw_cmd #(
   parameter SEND_WORDS = 128,
   parameter RECV_WORDS = 127,
   parameter FIFO_DEPTH = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   output reg [7:0] tx_data,
   output reg tx_valid,
   input wire tx_ready,
   input wire [7:0] rx_data,
   input wire rx_valid,
   output wire rx_ready
);
   localparam S_IDLE = 10'b0000000001;
   localparam S_CHECK = 10'b0000000010;
   localparam S_TXS = 10'b0000000100;
   localparam S_TXP = 10'b0000001000;
   localparam S_TXF = 10'b0000010000;
   localparam S_TXG = 10'b0000100000;
   localparam S_TXT = 10'b0001000000;
   localparam S_TXC = 10'b0010000000;
   localparam S_RXW = 10'b0100000000;
   localparam S_RXP = 10'b1000000000;

   reg [15:0] sbuf [0:SEND_WORDS-1];
   reg [15:0] rbuf [0:RECV_WORDS-1];
   reg [6:0] sidx;
   reg [6:0] ridx;
   reg [9:0] state;
   reg [11:0] seq;
   reg busy;
   reg done;
   reg err;
   reg [3:0] ecode;
   reg [7:0] ccode;
   reg [7:0] plen;
   reg [7:0] pidx;
   reg [7:0] fcs;
   reg [7:0] rfcs;
   reg [7:0] d1;
   reg [7:0] d2;
   reg [1:0] dcnt;
   reg [7:0] rcnt;
   reg [7:0] pbyte;
   reg [15:0] cmd_word;
   reg [31:0] rd_mux;
   reg next_ok;
   reg [3:0] next_ecode;
   reg [7:0] next_plen;
   wire wr_acc;
   wire rd_acc;
   wire start;
   wire abort;
   wire gp;
   wire tx_can;
   wire f_valid;
   wire f_ready;
   wire [7:0] f_data;
   wire [13:0] cnt_bin;
   wire [13:0] len_bin;
   integer i;
   integer j;

   function is_bcd4;
      input [15:0] w;
      begin
         is_bcd4 = (w[15:12] < 4'ha) && (w[11:8] < 4'ha) && (w[7:4] < 4'ha) && (w[3:0] < 4'ha);
      end
   endfunction

   function [13:0] bcd_to_bin;
      input [15:0] w;
      begin
         bcd_to_bin = w[15:12] * 14'd1000 + w[11:8] * 14'd100 + w[7:4] * 14'd10 + {10'h000, w[3:0]};
      end
   endfunction

   function [15:0] bin_to_bcd;
      input [7:0] v;
      reg [7:0] h;
      reg [7:0] t;
      reg [7:0] o;
      begin
         h = v / 8'd100;
         t = (v % 8'd100) / 8'd10;
         o = v % 8'd10;
         bin_to_bcd = {4'h0, h[3:0], t[3:0], o[3:0]};
      end
   endfunction

   function [7:0] nib_to_hex;
      input [3:0] n;
      begin
         nib_to_hex = (n < 4'ha) ? (`CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
      end
   endfunction

   function [3:0] hex_to_nib;
      input [7:0] c;
      reg [7:0] t;
      begin
         t = (c > 8'h40) ? (c - 8'h37) : (c - `CH_ZERO);
         hex_to_nib = t[3:0];
      end
   endfunction

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // Zero-wait slave: read data is latched in the setup cycle
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign start = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_START] && (state == S_IDLE);
   assign abort = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_ABORT];
   assign gp = (seq == `SEQ_GENERAL);
   assign tx_can = !tx_valid || tx_ready;
   // Reply bytes are drained only while a reply is expected; otherwise the FIFO backs up
   assign f_ready = (state == S_RXW) || (state == S_RXP);
   assign cnt_bin = bcd_to_bin(sbuf[0]);
   assign len_bin = bcd_to_bin(sbuf[1]);

   always @* begin
      rd_mux = 32'h00000000;
      case (paddr)
         `OFS_CTRL: rd_mux = {4'h0, seq, 16'h0000};
         `OFS_STATUS: rd_mux = {16'h0000, ccode, ecode, 1'b0, err, done, busy};
         `OFS_SEND_INDEX: rd_mux = {25'h0000000, sidx};
         `OFS_SEND_DATA: rd_mux = {16'h0000, sbuf[sidx]};
         `OFS_RECV_INDEX: rd_mux = {25'h0000000, ridx};
         `OFS_RECV_DATA: rd_mux = {16'h0000, rbuf[ridx]};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         sidx <= 7'h00;
         ridx <= 7'h00;
         for (i = 0; i < SEND_WORDS; i = i + 1) begin
            sbuf[i] <= 16'h0000;
         end
      end else begin
         if (psel && !penable) begin
            prdata <= rd_mux;
            pslverr <= (paddr > `OFS_RECV_DATA) || (paddr[1:0] != 2'b00);
         end
         if (wr_acc && paddr == `OFS_SEND_INDEX) begin
            sidx <= pwdata[6:0];
         end
         if (wr_acc && paddr == `OFS_SEND_DATA) begin
            sbuf[sidx] <= pwdata[15:0];
            if (sidx != SEND_WORDS[6:0] - 1'b1) begin
               sidx <= sidx + 1'b1;
            end
         end
         if (wr_acc && paddr == `OFS_RECV_INDEX) begin
            ridx <= pwdata[6:0];
         end
         // Reading the data port steps the index so software can stream the reply
         if (rd_acc && paddr == `OFS_RECV_DATA && ridx != RECV_WORDS[6:0] - 1'b1) begin
            ridx <= ridx + 1'b1;
         end
      end
   end

   always @* begin
      next_ok = 1'b1;
      next_ecode = `ERR_NONE;
      next_plen = `PLEN_CANCEL;
      case (seq)
         `SEQ_CANCEL: begin
            if (sbuf[0] != `CNT_CANCEL) begin
               next_ok = 1'b0;
               next_ecode = `ERR_COUNT;
            end
         end
         `SEQ_POLL_READ_CANCEL, `SEQ_POLL_WRITE_CANCEL: begin
            next_plen = `PLEN_POLL;
            if (sbuf[0] != `CNT_POLL) begin
               next_ok = 1'b0;
               next_ecode = `ERR_COUNT;
            end else if (sbuf[3][3:0] != `HEAD_CH1 && sbuf[3][3:0] != `HEAD_CH2) begin
               next_ok = 1'b0;
               next_ecode = `ERR_HEAD;
            end
         end
         `SEQ_GENERAL: begin
            next_plen = len_bin[7:0];
            if (!is_bcd4(sbuf[0]) || cnt_bin < `GP_CNT_MIN || cnt_bin > `GP_CNT_MAX) begin
               next_ok = 1'b0;
               next_ecode = `ERR_COUNT;
            end else if (!is_bcd4(sbuf[1]) || len_bin < `GP_LEN_MIN || len_bin > `GP_LEN_MAX) begin
               next_ok = 1'b0;
               next_ecode = `ERR_LENGTH;
            end else if (((len_bin + 14'd1) >> 1) > cnt_bin - 14'd2) begin
               next_ok = 1'b0;
               next_ecode = `ERR_LENGTH;
            end
         end
         default: begin
            next_ok = 1'b0;
            next_ecode = `ERR_SEQ;
         end
      endcase
   end

   always @* begin
      pbyte = 8'h00;
      cmd_word = (seq == `SEQ_CANCEL) ? `CMD_CANCEL :
                 (seq == `SEQ_POLL_READ_CANCEL) ? `CMD_POLL_READ_CANCEL : `CMD_POLL_WRITE_CANCEL;
      if (gp) begin
         // Two characters per word, upper byte first
         pbyte = pidx[0] ? sbuf[7'd2 + pidx[7:1]][7:0] : sbuf[7'd2 + pidx[7:1]][15:8];
      end else begin
         case (pidx)
            8'd0: pbyte = `CH_ZERO + {4'h0, sbuf[1][7:4]};
            8'd1: pbyte = `CH_ZERO + {4'h0, sbuf[1][3:0]};
            8'd2: pbyte = cmd_word[15:8];
            8'd3: pbyte = cmd_word[7:0];
            default: pbyte = `CH_ZERO + {4'h0, sbuf[3][3:0]};
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         seq <= 12'h000;
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         ecode <= `ERR_NONE;
         ccode <= 8'h00;
         plen <= 8'h00;
         pidx <= 8'h00;
         fcs <= 8'h00;
         rfcs <= 8'h00;
         d1 <= 8'h00;
         d2 <= 8'h00;
         dcnt <= 2'b00;
         rcnt <= 8'h00;
         tx_data <= 8'h00;
         tx_valid <= 1'b0;
         for (j = 0; j < RECV_WORDS; j = j + 1) begin
            rbuf[j] <= 16'h0000;
         end
      end else begin
         if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               if (start) begin
                  seq <= pwdata[`CTRL_SEQ_HI:`CTRL_SEQ_LO];
                  busy <= 1'b1;
                  done <= 1'b0;
                  err <= 1'b0;
                  ecode <= `ERR_NONE;
                  ccode <= 8'h00;
                  state <= S_CHECK;
               end
            end
            S_CHECK: begin
               pidx <= 8'h00;
               plen <= next_plen;
               fcs <= `CH_START;
               if (next_ok) begin
                  state <= S_TXS;
               end else begin
                  // Nothing goes on the link for a malformed request
                  busy <= 1'b0;
                  done <= 1'b1;
                  err <= 1'b1;
                  ecode <= next_ecode;
                  state <= S_IDLE;
               end
            end
            S_TXS: begin
               if (tx_can) begin
                  tx_data <= `CH_START;
                  tx_valid <= 1'b1;
                  state <= S_TXP;
               end
            end
            S_TXP: begin
               if (tx_can) begin
                  tx_data <= pbyte;
                  tx_valid <= 1'b1;
                  fcs <= fcs ^ pbyte;
                  pidx <= pidx + 1'b1;
                  if (pidx == plen - 1'b1) begin
                     state <= S_TXF;
                  end
               end
            end
            S_TXF: begin
               if (tx_can) begin
                  tx_data <= nib_to_hex(fcs[7:4]);
                  tx_valid <= 1'b1;
                  state <= S_TXG;
               end
            end
            S_TXG: begin
               if (tx_can) begin
                  tx_data <= nib_to_hex(fcs[3:0]);
                  tx_valid <= 1'b1;
                  state <= S_TXT;
               end
            end
            S_TXT: begin
               if (tx_can) begin
                  tx_data <= `CH_TERM;
                  tx_valid <= 1'b1;
                  state <= S_TXC;
               end
            end
            S_TXC: begin
               if (tx_can) begin
                  tx_data <= `CH_CR;
                  tx_valid <= 1'b1;
                  state <= S_RXW;
               end
            end
            S_RXW: begin
               if (f_valid && f_data == `CH_START) begin
                  rfcs <= `CH_START;
                  dcnt <= 2'b00;
                  rcnt <= 8'h00;
                  state <= S_RXP;
               end
            end
            S_RXP: begin
               if (f_valid && f_data == `CH_TERM) begin
                  // The two characters held back are the check pair, never payload
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
                  if (dcnt != 2'd2 || {hex_to_nib(d2), hex_to_nib(d1)} != rfcs) begin
                     err <= 1'b1;
                     ecode <= `ERR_FCS;
                  end
                  if (gp) begin
                     rbuf[0] <= bin_to_bcd(8'd1 + rcnt[7:1] + {7'h00, rcnt[0]});
                  end else begin
                     rbuf[0] <= `RESULT_CNT;
                     rbuf[1] <= {8'h00, ccode};
                  end
               end else if (f_valid) begin
                  d2 <= d1;
                  d1 <= f_data;
                  if (dcnt != 2'd2) begin
                     dcnt <= dcnt + 1'b1;
                  end else begin
                     rfcs <= rfcs ^ d2;
                     if (rcnt != `GP_LEN_MAX) begin
                        rcnt <= rcnt + 1'b1;
                     end
                     if (gp && rcnt != `GP_LEN_MAX) begin
                        if (!rcnt[0]) begin
                           rbuf[7'd1 + rcnt[7:1]] <= {d2, 8'h00};
                        end else begin
                           rbuf[7'd1 + rcnt[7:1]][7:0] <= d2;
                        end
                     end else if (!gp && rcnt == `CC_POS_HI) begin
                        ccode[7:4] <= hex_to_nib(d2);
                     end else if (!gp && rcnt == `CC_POS_LO) begin
                        ccode[3:0] <= hex_to_nib(d2);
                     end
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         // Abort has the last word so a silent controller cannot hang the block
         if (abort && state != S_IDLE) begin
            busy <= 1'b0;
            done <= 1'b1;
            err <= 1'b1;
            ecode <= `ERR_ABORT;
            state <= S_IDLE;
         end
      end
   end
endmodule // id_controller_cancel_and_raw_cmd

// [inc/idcmd_map.vh]
`ifndef IDCMD_MAP_VH
`define IDCMD_MAP_VH
// APB byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_SEND_INDEX 12'h008
`define OFS_SEND_DATA 12'h00c
`define OFS_RECV_INDEX 12'h010
`define OFS_RECV_DATA 12'h014
// Control word fields
`define CTRL_START 0
`define CTRL_ABORT 1
`define CTRL_SEQ_HI 27
`define CTRL_SEQ_LO 16
// Status word fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERROR 2
`define ST_ECODE_HI 7
`define ST_ECODE_LO 4
`define ST_CCODE_HI 15
`define ST_CCODE_LO 8
// Sequence numbers, BCD
`define SEQ_CANCEL 12'h543
`define SEQ_POLL_READ_CANCEL 12'h544
`define SEQ_POLL_WRITE_CANCEL 12'h545
`define SEQ_GENERAL 12'h546
// Fixed send word counts in BCD; general command ranges in binary
`define CNT_CANCEL 16'h0002
`define CNT_POLL 16'h0004
`define RESULT_CNT 16'h0002
`define GP_CNT_MIN 14'd3
`define GP_CNT_MAX 14'd128
`define GP_LEN_MIN 14'd1
`define GP_LEN_MAX 14'd251
`define HEAD_CH1 4'h1
`define HEAD_CH2 4'h2
// Frame characters
`define CH_START 8'h40
`define CH_TERM 8'h2a
`define CH_CR 8'h0d
`define CH_ZERO 8'h30
// Command characters sent to the tag controller (values are arbitrary)
`define CMD_CANCEL 16'h4141
`define CMD_POLL_READ_CANCEL 16'h5052
`define CMD_POLL_WRITE_CANCEL 16'h5057
// Payload lengths of the cancel frames
`define PLEN_CANCEL 8'd4
`define PLEN_POLL 8'd5
// Reply character positions that hold the completion code
`define CC_POS_HI 8'd4
`define CC_POS_LO 8'd5
// Error codes
`define ERR_NONE 4'h0
`define ERR_COUNT 4'h1
`define ERR_LENGTH 4'h2
`define ERR_HEAD 4'h3
`define ERR_SEQ 4'h4
`define ERR_FCS 4'h5
`define ERR_ABORT 4'h6
`endif

// [core/byte_fifo.v]
`timescale 1ns/1ns
`include "idcmd_map.vh"
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr;
   reg [AW-1:0] rptr;
   reg [AW:0] level;
   wire push;
   wire pop;
   integer i;

   assign in_ready = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data = mem[rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr <= {AW{1'b0}};
         rptr <= {AW{1'b0}};
         level <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem[wptr] <= in_data;
            wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
         end
         if (pop) begin
            rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule // byte_fifo

// [bench/idcmd_sva.sv]
`timescale 1ns/1ns
`include "idcmd_map.vh"
module idcmd_sva (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [7:0] tx_data,
   input wire tx_valid,
   input wire tx_ready,
   input wire [7:0] rx_data,
   input wire rx_valid,
   input wire rx_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && penable; endsequence
   sequence s_start; s_acc ##0 (pwrite && paddr == `OFS_CTRL && pwdata[`CTRL_START]); endsequence
   sequence s_term; tx_valid && tx_ready && tx_data == `CH_TERM; endsequence
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_hold: assert property (p_hold) else $error("tx byte changed before acceptance");
   property p_open; $rose(tx_valid) |-> tx_data == `CH_START; endproperty
   a_open: assert property (p_open) else $error("frame does not open with start char");
   property p_term_cr; s_term |=> tx_valid && tx_data == `CH_CR; endproperty
   a_term_cr: assert property (p_term_cr) else $error("terminator not followed by CR");
   property p_close; tx_valid && tx_ready && tx_data == `CH_CR |=> !tx_valid; endproperty
   a_close: assert property (p_close) else $error("tx still valid after CR");
   // Checking of the send block must come before any byte leaves
   property p_check; s_start ##0 !tx_valid |=> !tx_valid [*2]; endproperty
   a_check: assert property (p_check) else $error("byte sent before send block check");
   property p_unmap; s_acc ##0 (paddr > `OFS_RECV_DATA || paddr[1:0] != 2'b00) |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("no slave error on unmapped access");
   property p_map; s_acc ##0 (paddr <= `OFS_RECV_DATA && paddr[1:0] == 2'b00) |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("slave error on mapped access");
   property p_ready; psel |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("wait state inserted");
   property p_rst; $rose(presetn) |-> !tx_valid && rx_ready; endproperty
   a_rst: assert property (p_rst) else $error("link outputs wrong after reset");
endmodule // idcmd_sva
bind id_controller_cancel_and_raw_cmd idcmd_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
   .rx_valid(rx_valid), .rx_ready(rx_ready));

// [bench/tag_ctrl_model.sv]
`timescale 1ns/1ns
`include "idcmd_map.vh"
module tag_ctrl_model (
   input wire pclk,
   input wire presetn,
   input wire slow,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output logic tx_ready = 1'b0,
   output logic [7:0] rx_data = 8'h00,
   output logic rx_valid = 1'b0,
   input wire rx_ready
);
   logic [7:0] got[$];
   logic [7:0] rq[$];
   logic tick = 1'b0;
   // Noise in pre lands ahead of the frame, as a line glitch would
   task automatic reply(input string pre, input string p);
      logic [7:0] f;
      string h;
      f = `CH_START;
      foreach (pre[i]) rq.push_back(pre[i]);
      rq.push_back(`CH_START);
      foreach (p[i]) begin
         rq.push_back(p[i]);
         f = f ^ p[i];
      end
      h = $sformatf("%02X", f);
      rq.push_back(h[0]);
      rq.push_back(h[1]);
      rq.push_back(`CH_TERM);
      rq.push_back(`CH_CR);
   endtask
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
         tick <= 1'b0;
         rx_valid <= 1'b0;
      end else begin
         tick <= ~tick;
         tx_ready <= !slow || tick;
         if (tx_valid && tx_ready) got.push_back(tx_data);
         if (!rx_valid || rx_ready) begin
            if (rq.size() > 0) begin
               rx_data <= rq.pop_front();
               rx_valid <= 1'b1;
            end else begin
               // Idle line must not keep showing the last byte
               rx_data <= ~rx_data;
               rx_valid <= 1'b0;
            end
         end
      end
   end
endmodule // tag_ctrl_model

// [bench/id_controller_cancel_and_raw_cmd_bench.sv]
`timescale 1ns/1ns
`include "idcmd_map.vh"
module id_controller_cancel_and_raw_cmd_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic slow = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
   wire [7:0] tx_data;
   wire [7:0] rx_data;
   int err_total = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic se;
   always #20 pclk = ~pclk;
   id_controller_cancel_and_raw_cmd u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready));
   tag_ctrl_model u_tag (.pclk(pclk), .presetn(presetn), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run(input logic [11:0] s, input logic [15:0] w[$]);
      apb(1'b1, `OFS_SEND_INDEX, 32'h0);
      foreach (w[i]) apb(1'b1, `OFS_SEND_DATA, {16'h0000, w[i]});
      u_tag.got.delete();
      apb(1'b1, `OFS_CTRL, {4'h0, s, 15'h0000, 1'b1});
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         n++;
      end while (rd[`ST_DONE] !== 1'b1 && n < 200);
   endtask
   task automatic chk_frame(input string p);
      logic [7:0] f;
      string e;
      for (int n = 0; n < 400 && !(u_tag.got.size() > 0 && u_tag.got[$] == `CH_CR); n++) @(posedge pclk);
      f = `CH_START;
      foreach (p[i]) f = f ^ p[i];
      e = {"@", p, $sformatf("%02X", f), "*\r"};
      chk("frame length", u_tag.got.size(), e.len());
      foreach (e[i]) chk("frame byte", u_tag.got[i], e[i]);
   endtask
   task automatic recv2(input logic [31:0] w0, input logic [31:0] w1);
      apb(1'b1, `OFS_RECV_INDEX, 32'h0);
      apb(1'b0, `OFS_RECV_DATA, 32'h0);
      chk("result count", rd, w0);
      apb(1'b0, `OFS_RECV_DATA, 32'h0);
      chk("result word", rd, w1);
   endtask
   task automatic t_apb();
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped error", {31'h0, se}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, 12'h006, 32'h0);
      chk("unaligned error", {31'h0, se}, 32'h1);
   endtask
   task automatic t_cancel();
      logic [7:0] cc[4] = '{8'h00, 8'h14, 8'h75, 8'h76};
      foreach (cc[i]) begin
         run(`SEQ_CANCEL, '{16'h0002, 16'h0005});
         chk_frame("05AA");
         u_tag.reply("", {"05AA", $sformatf("%02X", cc[i])});
         wait_done();
         chk("cancel status", rd[15:0], {cc[i], 8'h02});
         recv2(32'h2, {24'h0, cc[i]});
      end
   endtask
   task automatic t_poll();
      logic [11:0] sq[2] = '{`SEQ_POLL_READ_CANCEL, `SEQ_POLL_WRITE_CANCEL};
      string cm[2] = '{"05PR", "05PW"};
      logic [7:0] cv[2] = '{8'h75, 8'h76};
      foreach (sq[i]) begin
         slow <= i[0];
         // Unused word carries junk that must be ignored
         run(sq[i], '{16'h0004, 16'h0005, 16'h0099, 16'(i + 1)});
         chk_frame({cm[i], $sformatf("%0d", i + 1)});
         u_tag.reply("", {cm[i], $sformatf("%02X", cv[i])});
         wait_done();
         chk("poll status", rd[15:0], {cv[i], 8'h02});
         recv2(32'h2, {24'h0, cv[i]});
      end
      slow <= 1'b0;
   endtask
   task automatic t_general();
      run(`SEQ_GENERAL, '{16'h0005, 16'h0005, 16'h4845, 16'h4c4c, 16'h4f00});
      chk_frame("HELLO");
      u_tag.reply("", "OK1");
      wait_done();
      chk("general status", rd[7:0], 8'h02);
      recv2(32'h3, 32'h4f4b);
      apb(1'b0, `OFS_RECV_DATA, 32'h0);
      chk("general tail", rd[15:8], 8'h31);
      apb(1'b0, `OFS_RECV_INDEX, 32'h0);
      chk("recv index", rd, 32'h3);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk("sequence readback", rd, {4'h0, `SEQ_GENERAL, 16'h0000});
      apb(1'b0, `OFS_SEND_INDEX, 32'h0);
      chk("send index", rd, 32'h5);
   endtask
   task automatic refuse(input logic [11:0] s, input logic [15:0] w[$], input logic [3:0] e);
      run(s, w);
      wait_done();
      chk("refused status", rd[7:0], {e, 4'h6});
      chk("refused bytes", u_tag.got.size(), 0);
   endtask
   task automatic t_refuse();
      refuse(`SEQ_GENERAL, '{16'h0002, 16'h0001}, `ERR_COUNT);
      refuse(`SEQ_GENERAL, '{16'h0129, 16'h0001, 16'h4100}, `ERR_COUNT);
      refuse(`SEQ_GENERAL, '{16'h000a, 16'h0001, 16'h4100}, `ERR_COUNT);
      refuse(`SEQ_GENERAL, '{16'h0003, 16'h0000, 16'h4100}, `ERR_LENGTH);
      refuse(`SEQ_GENERAL, '{16'h0003, 16'h0252, 16'h4100}, `ERR_LENGTH);
      refuse(`SEQ_POLL_READ_CANCEL, '{16'h0004, 16'h0005, 16'h0000, 16'h0003}, `ERR_HEAD);
      refuse(12'h547, '{16'h0002, 16'h0005}, `ERR_SEQ);
      refuse(`SEQ_CANCEL, '{16'h0003, 16'h0005}, `ERR_COUNT);
      refuse(`SEQ_POLL_WRITE_CANCEL, '{16'h0002, 16'h0005, 16'h0000, 16'h0001}, `ERR_COUNT);
      refuse(`SEQ_GENERAL, '{16'h0003, 16'h0003, 16'h4142}, `ERR_LENGTH);
      // A silent controller is only left by the abort bit
      run(`SEQ_CANCEL, '{16'h0002, 16'h0005});
      chk_frame("05AA");
      apb(1'b1, `OFS_CTRL, 32'h00000002);
      wait_done();
      chk("abort status", rd[7:0], {`ERR_ABORT, 4'h6});
   endtask
   task automatic t_fifo();
      // Reply arrives early behind noise, so the buffer fills before the frame goes out
      u_tag.reply("zzzzzzzzzzzz", "05AA00");
      repeat (30) @(posedge pclk);
      chk("rx refused when full", {31'h0, rx_ready}, 32'h0);
      run(`SEQ_CANCEL, '{16'h0002, 16'h0005});
      wait_done();
      chk("drained status", rd[15:0], 16'h0002);
      chk("model drained", u_tag.rq.size(), 0);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_apb();
      t_cancel();
      t_poll();
      t_general();
      t_refuse();
      t_fifo();
      stop_test();
   end
   initial begin
      #2000000;
      err_total++;
      stop_test();
   end
endmodule // id_controller_cancel_and_raw_cmd_bench
